/* File: seq_pkg.sv */
// Constants, register map and state codes of the bridge sequencer
`default_nettype none
package seq_pkg;
	// Clock and timing
	localparam int CLK_KHZ = 100_000;
	localparam int SOFT_FREQ_KHZ = 360;
	localparam int SOFT_PERIOD_CYC = CLK_KHZ / SOFT_FREQ_KHZ;
	localparam int PRE_TIMEOUT_MS = 20;
	localparam int PRE_TIMEOUT_CYC = PRE_TIMEOUT_MS * CLK_KHZ;
	localparam int WAIT_TIME_US = 1000;
	localparam int WAIT_CYC = WAIT_TIME_US * CLK_KHZ / 1000;
	localparam int STEP_TIME_US = 10;
	localparam int STEP_CYC = STEP_TIME_US * CLK_KHZ / 1000;
	localparam int SYNC_MAX_PERIOD_NS = 22500;
	localparam int SYNC_MAX_CYC = SYNC_MAX_PERIOD_NS * (CLK_KHZ / 1000) / 1000;
	localparam int SYNC_CYCLES = 3;
	localparam int TEST_CYC = 8;
	// Widths
	localparam int PER_W = 16;
	localparam int DUTY_W = 7;
	localparam int LIM_W = 3;
	// Limits and levels
	localparam logic [DUTY_W-1:0] DUTY_PRE_LIMIT = 7'h2d;
	localparam logic [DUTY_W-1:0] DUTY_FULL = 7'h64;
	localparam logic [LIM_W-1:0] LIMIT_START = 3'h6;
	// Register offsets
	localparam logic [3:0] REG_PERIOD = 4'h0;
	localparam logic [3:0] REG_DUTY = 4'h4;
	localparam logic [3:0] REG_LIMIT = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hc;
	// Field positions
	localparam int LIM_A_LSB = 0;
	localparam int LIM_B_LSB = 4;
	localparam int BYPASS_BIT = 8;
	localparam int STAT_READY_BIT = 4;
	localparam int STAT_PER_LSB = 16;
	// Reset values
	localparam logic [PER_W-1:0] PERIOD_RST = 16'h03e8;
	localparam logic [DUTY_W-1:0] DUTY_RST = 7'h32;
	localparam logic [LIM_W-1:0] LIMIT_RST = 3'h4;
	typedef enum logic [3:0] {
		ST_OFF = 4'h0,
		ST_CFG = 4'h1,
		ST_SYNC = 4'h2,
		ST_TEST = 4'h3,
		ST_PRE = 4'h4,
		ST_SOFT = 4'h5,
		ST_RUN = 4'h6,
		ST_FAULT = 4'h7,
		ST_WAIT = 4'h8
	} state_t;
endpackage : seq_pkg
`default_nettype wire

/* File: bridge_pwm.sv */
// Full-bridge pulse generator, A in first half, B in second half
`timescale 1ns/100ps
`default_nettype none
module bridge_pwm #(
	parameter int PER_W = seq_pkg::PER_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Control
	input wire logic enable_i,
	input wire logic [PER_W-1:0] period_i,
	input wire logic [PER_W-1:0] on_i,
	// Pulses
	output logic a_o,
	output logic b_o
);
	logic [PER_W-1:0] cnt_r;
	logic [PER_W-1:0] half;
	logic [PER_W:0] b_end;

	assign half = period_i >> 1;
	assign b_end = {1'b0, half} + {1'b0, on_i};

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_r <= '0;
		end else if (!enable_i || cnt_r >= period_i - 1'b1) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			a_o <= 1'b0;
			b_o <= 1'b0;
		end else begin
			a_o <= enable_i && (cnt_r < on_i);
			b_o <= enable_i && (cnt_r >= half) && ({1'b0, cnt_r} < b_end);
		end
	end
endmodule : bridge_pwm
`default_nettype wire

/* File: sync_meter.sv */
// Measures period and high time of an external PWM, flags lock and loss
`timescale 1ns/100ps
`default_nettype none
module sync_meter #(
	parameter int PER_W = seq_pkg::PER_W,
	parameter int MAX_CYC = seq_pkg::SYNC_MAX_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Control and pin
	input wire logic enable_i,
	input wire logic sync_i,
	// Results
	output logic locked_o,
	output logic lost_o,
	output logic [PER_W-1:0] period_o,
	output logic [PER_W-1:0] high_o
);
	localparam logic [2:0] LOCK_EDGES = 3'(seq_pkg::SYNC_CYCLES + 1);
	logic prev_r;
	logic [2:0] edges_r;
	logic [PER_W-1:0] cnt_r;
	logic [PER_W-1:0] high_r;
	logic rise;

	assign rise = sync_i && !prev_r;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			prev_r <= 1'b0;
			edges_r <= '0;
			cnt_r <= '0;
			high_r <= '0;
			period_o <= '0;
			high_o <= '0;
		end else if (!enable_i) begin
			prev_r <= sync_i;
			edges_r <= '0;
			cnt_r <= '0;
			high_r <= '0;
		end else begin
			prev_r <= sync_i;
			if (rise) begin
				cnt_r <= '0;
				high_r <= '0;
				if (edges_r != '0) begin
					period_o <= cnt_r + 1'b1;
					high_o <= high_r;
				end
				if (edges_r != LOCK_EDGES) begin
					edges_r <= edges_r + 1'b1;
				end
			end else begin
				if (cnt_r != '1) begin
					cnt_r <= cnt_r + 1'b1;
				end
				if (sync_i && high_r != '1) begin
					high_r <= high_r + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			locked_o <= 1'b0;
			lost_o <= 1'b0;
		end else begin
			locked_o <= enable_i && (edges_r == LOCK_EDGES);
			lost_o <= enable_i && (edges_r != '0) &&
				(cnt_r >= PER_W'(MAX_CYC));
		end
	end
endmodule : sync_meter
`default_nettype wire

/* File: bridge_driver_state_sequencer.sv */
// Operating-state sequencer of the full-bridge transformer driver
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module bridge_driver_state_sequencer #(
	parameter int PRE_TIMEOUT_CYC = seq_pkg::PRE_TIMEOUT_CYC,
	parameter int WAIT_CYC = seq_pkg::WAIT_CYC,
	parameter int STEP_CYC = seq_pkg::STEP_CYC,
	parameter int SYNC_MAX_CYC = seq_pkg::SYNC_MAX_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Register port
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic we_i,
	input wire logic re_i,
	output logic [31:0] rdata_o,
	// Supervision and sense inputs
	input wire logic uvlo_ok_i,
	input wire logic rate_or_sync_input_i,
	input wire logic precharge_done_i,
	input wire logic short_i,
	input wire logic peak_trip_i,
	input wire logic avg_oc_i,
	input wire logic overtemp_i,
	// Bridge outputs
	output logic bridge_out_a_o,
	output logic bridge_out_a_oe_n_o,
	output logic bridge_out_b_o,
	output logic bridge_out_b_oe_n_o,
	output logic precharge_source_o,
	output logic [2:0] peak_limit_a_o,
	output logic [2:0] peak_limit_b_o,
	// Ready flag
	output logic ready_o
);
	localparam int PW = seq_pkg::PER_W;
	localparam int DW = seq_pkg::DUTY_W;
	localparam int LW = seq_pkg::LIM_W;
	localparam logic [PW-1:0] SOFT_PER = PW'(seq_pkg::SOFT_PERIOD_CYC);

	function automatic logic [PW-1:0] on_from_duty(input logic [PW-1:0] per,
		input logic [DW-1:0] duty);
		logic [PW+DW-1:0] prod;
		prod = (PW+DW)'(per) * (PW+DW)'(duty);
		on_from_duty = PW'(prod / (PW+DW)'(seq_pkg::DUTY_FULL));
	endfunction : on_from_duty

	function automatic logic [PW-1:0] clamp_half(input logic [PW-1:0] on,
		input logic [PW-1:0] per);
		clamp_half = (on > (per >> 1)) ? (per >> 1) : on;
	endfunction : clamp_half

	function automatic logic [LW-1:0] step_to(input logic [LW-1:0] cur,
		input logic [LW-1:0] tgt);
		if (cur > tgt) begin
			step_to = cur - 1'b1;
		end else if (cur < tgt) begin
			step_to = cur + 1'b1;
		end else begin
			step_to = cur;
		end
	endfunction : step_to

	// Software registers
	logic [PW-1:0] per_reg_r;
	logic [DW-1:0] duty_reg_r;
	logic [LW-1:0] lim_a_reg_r;
	logic [LW-1:0] lim_b_reg_r;
	logic bypass_reg_r;
	// Latched configuration
	logic [PW-1:0] tgt_per_r;
	logic [DW-1:0] tgt_duty_r;
	logic [PW-1:0] meas_on_r;
	logic bypass_act_r;
	logic [LW-1:0] tgt_a_r;
	logic [LW-1:0] tgt_b_r;
	// Sequencer state
	seq_pkg::state_t state_r;
	seq_pkg::state_t state_nxt;
	logic [PW-1:0] cur_per_r;
	logic [LW-1:0] lim_a_r;
	logic [LW-1:0] lim_b_r;
	logic [31:0] step_cnt_r;
	logic [31:0] pre_cnt_r;
	logic [31:0] wait_cnt_r;
	logic [7:0] test_cnt_r;
	// Derived
	logic meas_locked;
	logic meas_lost;
	logic [PW-1:0] meas_per;
	logic [PW-1:0] meas_high;
	logic pwm_a;
	logic pwm_b;
	logic [PW-1:0] on_now;
	logic [PW+DW-1:0] on_pct;
	logic [PW+DW-1:0] per_pct;
	logic pre_needed;
	logic test_end;
	logic pre_timeout;
	logic wait_end;
	logic step_tick;
	logic fault_live;
	logic soft_done;
	logic soft_entry;
	logic [PW-1:0] soft_start_per;

	// External PWM measurement in bypass mode
	sync_meter #(
		.PER_W(PW),
		.MAX_CYC(SYNC_MAX_CYC)
	) u_meter (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.enable_i(bypass_act_r && state_r != seq_pkg::ST_OFF &&
			state_r != seq_pkg::ST_CFG),
		.sync_i(rate_or_sync_input_i),
		.locked_o(meas_locked),
		.lost_o(meas_lost),
		.period_o(meas_per),
		.high_o(meas_high)
	);

	// Bridge switching
	bridge_pwm #(
		.PER_W(PW)
	) u_pwm (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.enable_i(state_r == seq_pkg::ST_SOFT || state_r == seq_pkg::ST_RUN),
		.period_i(cur_per_r),
		.on_i(on_now),
		.a_o(pwm_a),
		.b_o(pwm_b)
	);

	assign on_now = bypass_act_r ? clamp_half(meas_on_r, cur_per_r) :
		clamp_half(on_from_duty(cur_per_r, tgt_duty_r), cur_per_r);
	assign on_pct = (PW+DW)'(meas_on_r) * (PW+DW)'(seq_pkg::DUTY_FULL);
	assign per_pct = (PW+DW)'(tgt_per_r) * (PW+DW)'(seq_pkg::DUTY_PRE_LIMIT);
	assign pre_needed = bypass_act_r ? (on_pct < per_pct) :
		(tgt_duty_r < seq_pkg::DUTY_PRE_LIMIT);
	assign test_end = test_cnt_r == 8'(seq_pkg::TEST_CYC - 1);
	assign pre_timeout = pre_cnt_r == 32'(PRE_TIMEOUT_CYC - 1);
	assign wait_end = wait_cnt_r == 32'(WAIT_CYC - 1);
	assign step_tick = step_cnt_r == 32'(STEP_CYC - 1);
	assign fault_live = avg_oc_i || overtemp_i || peak_trip_i ||
		(bypass_act_r && meas_lost);
	assign soft_done = cur_per_r == tgt_per_r && lim_a_r == tgt_a_r &&
		lim_b_r == tgt_b_r && !peak_trip_i;
	assign soft_entry = state_r != seq_pkg::ST_SOFT &&
		state_nxt == seq_pkg::ST_SOFT;
	assign soft_start_per = (tgt_per_r > SOFT_PER) ? SOFT_PER :
		tgt_per_r;

	// Register writes
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			per_reg_r <= seq_pkg::PERIOD_RST;
			duty_reg_r <= seq_pkg::DUTY_RST;
			lim_a_reg_r <= seq_pkg::LIMIT_RST;
			lim_b_reg_r <= seq_pkg::LIMIT_RST;
			bypass_reg_r <= 1'b0;
		end else if (we_i) begin
			case (addr_i)
				seq_pkg::REG_PERIOD: begin
					per_reg_r <= wdata_i[PW-1:0];
				end
				seq_pkg::REG_DUTY: begin
					duty_reg_r <= wdata_i[DW-1:0];
				end
				seq_pkg::REG_LIMIT: begin
					lim_a_reg_r <= wdata_i[seq_pkg::LIM_A_LSB +: LW];
					lim_b_reg_r <= wdata_i[seq_pkg::LIM_B_LSB +: LW];
					bypass_reg_r <= wdata_i[seq_pkg::BYPASS_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// Register reads, data valid one cycle after the strobe
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= '0;
			if (re_i) begin
				case (addr_i)
					seq_pkg::REG_PERIOD: begin
						rdata_o[PW-1:0] <= per_reg_r;
					end
					seq_pkg::REG_DUTY: begin
						rdata_o[DW-1:0] <= duty_reg_r;
					end
					seq_pkg::REG_LIMIT: begin
						rdata_o[seq_pkg::LIM_A_LSB +: LW] <= lim_a_reg_r;
						rdata_o[seq_pkg::LIM_B_LSB +: LW] <= lim_b_reg_r;
						rdata_o[seq_pkg::BYPASS_BIT] <= bypass_reg_r;
					end
					seq_pkg::REG_STATUS: begin
						rdata_o[3:0] <= state_r;
						rdata_o[seq_pkg::STAT_READY_BIT] <= ready_o;
						rdata_o[seq_pkg::STAT_PER_LSB +: PW] <= cur_per_r;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			seq_pkg::ST_OFF: begin
				state_nxt = seq_pkg::ST_CFG;
			end
			seq_pkg::ST_CFG: begin
				state_nxt = bypass_reg_r ? seq_pkg::ST_SYNC : seq_pkg::ST_TEST;
			end
			seq_pkg::ST_SYNC: begin
				if (meas_locked) begin
					state_nxt = seq_pkg::ST_TEST;
				end
			end
			seq_pkg::ST_TEST: begin
				if (short_i) begin
					state_nxt = seq_pkg::ST_FAULT;
				end else if (test_end) begin
					state_nxt = pre_needed ? seq_pkg::ST_PRE :
						seq_pkg::ST_SOFT;
				end
			end
			seq_pkg::ST_PRE: begin
				if (precharge_done_i) begin
					state_nxt = seq_pkg::ST_SOFT;
				end else if (pre_timeout) begin
					state_nxt = seq_pkg::ST_FAULT;
				end
			end
			seq_pkg::ST_SOFT: begin
				if (soft_done) begin
					state_nxt = seq_pkg::ST_RUN;
				end
			end
			seq_pkg::ST_RUN: begin
				if (fault_live) begin
					state_nxt = seq_pkg::ST_FAULT;
				end
			end
			seq_pkg::ST_FAULT: begin
				if (!fault_live) begin
					state_nxt = seq_pkg::ST_WAIT;
				end
			end
			seq_pkg::ST_WAIT: begin
				if (wait_end) begin
					state_nxt = seq_pkg::ST_TEST;
				end
			end
			default: begin
				state_nxt = seq_pkg::ST_OFF;
			end
		endcase
		if (!uvlo_ok_i) begin
			state_nxt = seq_pkg::ST_OFF;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_r <= seq_pkg::ST_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Configuration latch
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tgt_per_r <= seq_pkg::PERIOD_RST;
			tgt_duty_r <= seq_pkg::DUTY_RST;
			meas_on_r <= '0;
			bypass_act_r <= 1'b0;
			tgt_a_r <= seq_pkg::LIMIT_RST;
			tgt_b_r <= seq_pkg::LIMIT_RST;
		end else if (state_r == seq_pkg::ST_CFG) begin
			tgt_per_r <= per_reg_r;
			tgt_duty_r <= duty_reg_r;
			bypass_act_r <= bypass_reg_r;
			tgt_a_r <= lim_a_reg_r;
			tgt_b_r <= lim_b_reg_r;
		end else if (state_r == seq_pkg::ST_SYNC && meas_locked) begin
			tgt_per_r <= meas_per;
			meas_on_r <= meas_high;
		end
	end

	// Timers for self-test, pre-charge and wait
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			test_cnt_r <= '0;
			pre_cnt_r <= '0;
			wait_cnt_r <= '0;
		end else begin
			test_cnt_r <= (state_r == seq_pkg::ST_TEST) ?
				test_cnt_r + 1'b1 : '0;
			pre_cnt_r <= (state_r == seq_pkg::ST_PRE) ?
				pre_cnt_r + 1'b1 : '0;
			wait_cnt_r <= (state_r == seq_pkg::ST_WAIT) ?
				wait_cnt_r + 1'b1 : '0;
		end
	end

	// Soft-start ramps of period and peak limits
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cur_per_r <= seq_pkg::PERIOD_RST;
			lim_a_r <= seq_pkg::LIMIT_START;
			lim_b_r <= seq_pkg::LIMIT_START;
			step_cnt_r <= '0;
		end else if (soft_entry) begin
			cur_per_r <= soft_start_per;
			lim_a_r <= seq_pkg::LIMIT_START;
			lim_b_r <= seq_pkg::LIMIT_START;
			step_cnt_r <= '0;
		end else if (state_r == seq_pkg::ST_SOFT) begin
			step_cnt_r <= step_tick ? '0 : step_cnt_r + 1'b1;
			if (step_tick && !peak_trip_i) begin
				if (cur_per_r < tgt_per_r) begin
					cur_per_r <= cur_per_r + 1'b1;
				end
				lim_a_r <= step_to(lim_a_r, tgt_a_r);
				lim_b_r <= step_to(lim_b_r, tgt_b_r);
			end
		end else if (state_r != seq_pkg::ST_RUN) begin
			cur_per_r <= tgt_per_r;
			lim_a_r <= seq_pkg::LIMIT_START;
			lim_b_r <= seq_pkg::LIMIT_START;
			step_cnt_r <= '0;
		end
	end

	// Output stage
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bridge_out_a_o <= 1'b0;
			bridge_out_a_oe_n_o <= 1'b1;
			bridge_out_b_o <= 1'b0;
			bridge_out_b_oe_n_o <= 1'b1;
			precharge_source_o <= 1'b0;
		end else begin
			bridge_out_a_o <= 1'b0;
			bridge_out_a_oe_n_o <= 1'b1;
			bridge_out_b_o <= 1'b0;
			bridge_out_b_oe_n_o <= 1'b1;
			precharge_source_o <= 1'b0;
			case (state_r)
				seq_pkg::ST_TEST: begin
					bridge_out_a_oe_n_o <= test_cnt_r[0];
					bridge_out_b_oe_n_o <= test_cnt_r[0];
				end
				seq_pkg::ST_PRE: begin
					bridge_out_a_oe_n_o <= 1'b0;
					precharge_source_o <= 1'b1;
				end
				seq_pkg::ST_SOFT, seq_pkg::ST_RUN: begin
					bridge_out_a_o <= pwm_a;
					bridge_out_a_oe_n_o <= 1'b0;
					bridge_out_b_o <= pwm_b;
					bridge_out_b_oe_n_o <= 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ready_o <= 1'b0;
			peak_limit_a_o <= seq_pkg::LIMIT_START;
			peak_limit_b_o <= seq_pkg::LIMIT_START;
		end else begin
			ready_o <= state_r == seq_pkg::ST_RUN;
			peak_limit_a_o <= lim_a_r;
			peak_limit_b_o <= lim_b_r;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	property p_pre_drive;
		state_r == seq_pkg::ST_PRE |=> !bridge_out_a_o &&
			!bridge_out_a_oe_n_o && bridge_out_b_oe_n_o && precharge_source_o;
	endproperty
	a_pre_drive: assert property (p_pre_drive)
		else $error("pre-charge drive wrong");

	property p_pre_skip;
		state_r == seq_pkg::ST_TEST && test_end && !short_i && uvlo_ok_i &&
			!pre_needed |=> state_r == seq_pkg::ST_SOFT;
	endproperty
	a_pre_skip: assert property (p_pre_skip)
		else $error("pre-charge not skipped");

	property p_pre_timeout;
		state_r == seq_pkg::ST_PRE && pre_timeout && !precharge_done_i &&
			uvlo_ok_i |=> state_r == seq_pkg::ST_FAULT;
	endproperty
	a_pre_timeout: assert property (p_pre_timeout)
		else $error("pre-charge timeout missed");

	property p_soft_freq;
		state_r != seq_pkg::ST_SOFT ##1 state_r == seq_pkg::ST_SOFT |->
			cur_per_r == soft_start_per;
	endproperty
	a_soft_freq: assert property (p_soft_freq)
		else $error("soft start period wrong");

	property p_soft_limit;
		state_r != seq_pkg::ST_SOFT ##1 state_r == seq_pkg::ST_SOFT |->
			lim_a_r == seq_pkg::LIMIT_START && lim_b_r == seq_pkg::LIMIT_START;
	endproperty
	a_soft_limit: assert property (p_soft_limit)
		else $error("soft start limit not six");

	property p_soft_hold;
		state_r == seq_pkg::ST_SOFT && peak_trip_i && uvlo_ok_i |=>
			state_r == seq_pkg::ST_SOFT;
	endproperty
	a_soft_hold: assert property (p_soft_hold)
		else $error("soft start left under peak trip");

	property p_ready;
		state_r == seq_pkg::ST_SOFT ##1 state_r == seq_pkg::ST_RUN |=> ready_o;
	endproperty
	a_ready: assert property (p_ready)
		else $error("ready not raised");

	property p_run_fault;
		state_r == seq_pkg::ST_RUN && uvlo_ok_i &&
			(avg_oc_i || peak_trip_i || overtemp_i) |=>
			state_r == seq_pkg::ST_FAULT;
	endproperty
	a_run_fault: assert property (p_run_fault)
		else $error("run fault missed");

	property p_uvlo;
		!uvlo_ok_i |=> state_r == seq_pkg::ST_OFF;
	endproperty
	a_uvlo: assert property (p_uvlo)
		else $error("undervoltage not off");

	property p_fault_out;
		state_r == seq_pkg::ST_FAULT |=> bridge_out_a_oe_n_o &&
			bridge_out_b_oe_n_o && !ready_o;
	endproperty
	a_fault_out: assert property (p_fault_out)
		else $error("fault outputs wrong");

	property p_wait;
		state_r == seq_pkg::ST_WAIT && wait_end && uvlo_ok_i |=>
			state_r == seq_pkg::ST_TEST;
	endproperty
	a_wait: assert property (p_wait)
		else $error("wait did not restart");
endmodule : bridge_driver_state_sequencer
`default_nettype wire

/* File: far_side.sv */
// Far-side model: series capacitor charge and external PWM source
`timescale 1ns/100ps
`default_nettype none
module far_side (
	// Clock
	input wire logic clk_i,
	// Control from sequencer and bench
	input wire logic charge_i,
	input wire logic stall_i,
	input wire logic sync_en_i,
	// Sense back to sequencer
	output logic done_o,
	output logic sync_o
);
	int chg = 0;
	int ph = 0;
	// Capacitor charges only while the source is on; stall never ends
	always @(posedge clk_i) begin
		chg <= charge_i ? chg + 1 : 0;
		done_o <= charge_i && !stall_i && chg >= 29;
	end
	// External PWM, 40-cycle period, 12 high; low once stopped
	always @(posedge clk_i) begin
		ph <= (ph == 39) ? 0 : ph + 1;
		sync_o <= sync_en_i && ph < 12;
	end
endmodule : far_side
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench of the bridge sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
	typedef struct {logic [31:0] v; logic [31:0] m;} note_t;
	localparam logic [31:0] STM = 32'h0000_001f;
	localparam logic [31:0] FULL = 32'hffff_001f;
	note_t notes[$];
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [31:0] wdata_i = 32'h0000_0000;
	logic we_i = 1'b0;
	logic re_i = 1'b0;
	logic uvlo_ok_i = 1'b0;
	logic short_i = 1'b0;
	logic peak_trip_i = 1'b0;
	logic avg_oc_i = 1'b0;
	logic overtemp_i = 1'b0;
	logic stall = 1'b0;
	logic sync_en = 1'b0;
	logic re_d = 1'b0;
	logic [31:0] rdata_o;
	logic [31:0] st;
	logic sync_w, done_w, out_a, oe_a, out_b, oe_b, src, ready_o;
	logic [2:0] lim_a, lim_b, ta, tb;
	logic [15:0] per;
	logic [6:0] duty;
	int mismatches = 0;
	int check_count = 0;
	int ra, rb;

	always #5 clk_i = ~clk_i;

	bridge_driver_state_sequencer #(.PRE_TIMEOUT_CYC(200), .WAIT_CYC(50),
		.STEP_CYC(4), .SYNC_MAX_CYC(100)) uut (.clk_i(clk_i),
		.resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
		.uvlo_ok_i(uvlo_ok_i), .rate_or_sync_input_i(sync_w),
		.precharge_done_i(done_w), .short_i(short_i),
		.peak_trip_i(peak_trip_i), .avg_oc_i(avg_oc_i),
		.overtemp_i(overtemp_i), .bridge_out_a_o(out_a),
		.bridge_out_a_oe_n_o(oe_a), .bridge_out_b_o(out_b),
		.bridge_out_b_oe_n_o(oe_b), .precharge_source_o(src),
		.peak_limit_a_o(lim_a), .peak_limit_b_o(lim_b),
		.ready_o(ready_o));

	far_side partner (.clk_i(clk_i), .charge_i(src), .stall_i(stall),
		.sync_en_i(sync_en), .done_o(done_w), .sync_o(sync_w));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict

	function automatic logic [31:0] ex(input seq_pkg::state_t s,
		input logic r, input logic [15:0] p);
		return {p, 11'h000, r, s};
	endfunction : ex

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		we_i <= 1'b1;
		@(posedge clk_i);
		we_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] v,
		input logic [31:0] m);
		@(posedge clk_i);
		addr_i <= a;
		re_i <= 1'b1;
		notes.push_back('{v, m});
		@(posedge clk_i);
		re_i <= 1'b0;
		@(posedge clk_i);
		st = rdata_o;
	endtask : rd

	task automatic wait_st(input seq_pkg::state_t s);
		for (int i = 0; i < 600; i++) begin
			rd(seq_pkg::REG_STATUS, 32'h0, 32'h0);
			if (st[3:0] === s) begin
				return;
			end
		end
		chk(32'(st[3:0]), 32'(s));
		give_verdict();
	endtask : wait_st

	task automatic cfg(input logic [15:0] p, input logic [6:0] d,
		input logic b);
		wr(seq_pkg::REG_PERIOD, 32'(p));
		wr(seq_pkg::REG_DUTY, 32'(d));
		wr(seq_pkg::REG_LIMIT, 32'({b, 1'b0, tb, 1'b0, ta}));
		@(posedge clk_i);
		uvlo_ok_i <= 1'b1;
	endtask : cfg

	// Read results compared in arrival order
	always @(posedge clk_i) begin
		if (re_d && notes.size() > 0) begin
			if (notes[0].m !== 32'h0) begin
				chk(rdata_o & notes[0].m, notes[0].v);
			end
			void'(notes.pop_front());
		end
		re_d <= re_i;
	end

	initial begin
		void'($urandom(68830));
		per = 16'($urandom_range(300, 278));
		duty = 7'($urandom_range(44, 10));
		ta = 3'($urandom_range(5, 1));
		tb = 3'($urandom_range(5, 1));
		cyc(4);
		chk(32'({oe_a, oe_b, ready_o, lim_a, lim_b}), 32'h0000_01b6);
		resetn_i <= 1'b1;
		rd(seq_pkg::REG_STATUS, ex(seq_pkg::ST_OFF, 0, 0), STM);
		rd(seq_pkg::REG_PERIOD, 32'(seq_pkg::PERIOD_RST), 32'h0000_ffff);
		wr(4'h2, 32'hffff_ffff);
		rd(4'h2, 32'h0, 32'hffff_ffff);
		cfg(per, duty, 1'b0);
		wait_st(seq_pkg::ST_PRE);
		cyc(2);
		chk(32'({out_a, oe_a, src}), 32'h0000_0001);
		peak_trip_i <= 1'b1;
		wait_st(seq_pkg::ST_SOFT);
		cyc(100);
		rd(seq_pkg::REG_STATUS, ex(seq_pkg::ST_SOFT, 0, 277), FULL);
		chk(32'({lim_a, lim_b}), 32'h0000_0036);
		peak_trip_i <= 1'b0;
		wait_st(seq_pkg::ST_RUN);
		cyc(2);
		rd(seq_pkg::REG_STATUS, ex(seq_pkg::ST_RUN, 1, per), FULL);
		chk(32'({lim_a, lim_b}), 32'({ta, tb}));
		ra = 0;
		rb = 0;
		repeat (2 * per) begin
			@(posedge clk_i);
			ra += out_a;
			rb += out_b;
		end
		chk(32'({ra > 0, rb > 0, oe_a, oe_b, ready_o}), 32'h0000_0019);
		for (int k = 0; k < 4; k++) begin
			{short_i, overtemp_i, avg_oc_i, peak_trip_i} <= 4'h1 << k;
			wait_st(seq_pkg::ST_FAULT);
			cyc(20);
			rd(seq_pkg::REG_STATUS, ex((k < 3) ? seq_pkg::ST_FAULT :
				seq_pkg::ST_WAIT, 0, 0), STM);
			chk(32'({oe_a, oe_b, ready_o}), 32'h0000_0006);
			{short_i, overtemp_i, avg_oc_i, peak_trip_i} <= 4'h0;
			wait_st(seq_pkg::ST_WAIT);
			cyc(2);
			chk(32'({oe_a, oe_b, ready_o}), 32'h0000_0006);
			wait_st(seq_pkg::ST_TEST);
			if (k < 2) begin
				wait_st(seq_pkg::ST_RUN);
			end
		end
		stall <= 1'b1;
		wait_st(seq_pkg::ST_PRE);
		cyc(150);
		rd(seq_pkg::REG_STATUS, ex(seq_pkg::ST_PRE, 0, 0), STM);
		wait_st(seq_pkg::ST_FAULT);
		stall <= 1'b0;
		wait_st(seq_pkg::ST_RUN);
		uvlo_ok_i <= 1'b0;
		cyc(3);
		chk(32'({oe_a, oe_b, ready_o}), 32'h0000_0006);
		rd(seq_pkg::REG_STATUS, ex(seq_pkg::ST_OFF, 0, 0), STM);
		stall <= 1'b1;
		cfg(16'd250, 7'd45, 1'b0);
		wait_st(seq_pkg::ST_TEST);
		peak_trip_i <= 1'b1;
		wait_st(seq_pkg::ST_SOFT);
		rd(seq_pkg::REG_STATUS, ex(seq_pkg::ST_SOFT, 0, 250), FULL);
		peak_trip_i <= 1'b0;
		wait_st(seq_pkg::ST_RUN);
		stall <= 1'b0;
		uvlo_ok_i <= 1'b0;
		sync_en <= 1'b1;
		cyc(3);
		cfg(per, duty, 1'b1);
		wait_st(seq_pkg::ST_SYNC);
		wait_st(seq_pkg::ST_TEST);
		wait_st(seq_pkg::ST_RUN);
		sync_en <= 1'b0;
		wait_st(seq_pkg::ST_FAULT);
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
